// >>> plp_dev.sv
// device end: serial control, port pins, lock detection and clock output
`timescale 1ns/100ps
`default_nettype none
module plp_dev
  import plp_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // serial link
  plp_link_if.dev link,
  // synthesizer side
  input wire logic [3:0] ref_select_bits,
  input wire logic [1:0] xtal_sel,
  input wire logic ref_pulse,
  input wire logic div_pulse,
  output logic standby,
  output logic [3:0] counter_sel,
  output logic test_mode,
  // open-drain pins
  output logic [3:0] open_drain_pins_o,
  output logic [3:0] open_drain_pins_oe,
  // bidirectional pins, index 0 shared with clock output
  input wire logic [4:0] bidir_pins_i,
  output logic [4:0] bidir_pins_o,
  output logic [4:0] bidir_pins_oe,
  // phase comparator pins
  output logic phase_out_a_o,
  output logic phase_out_a_oe,
  output logic phase_out_b_o,
  output logic phase_out_b_oe
);
  import plp_pkg::*;

  // phase error in steps, saturating at seven; past half a cycle only unlock is trustworthy,
  // so the field means something only while unlock stays clear
  function automatic logic [2:0] pe_quant(input logic [15:0] v);
    logic [2:0] q;
    q = 3'h0;
    for (int i = 1; i < 8; i++) begin
      if ({16'h0000, v} >= 32'(i) * {16'h0000, PE_STEP_CYC}) begin
        q = 3'(i);
      end
    end
    return q;
  endfunction

  logic sclk_s, ce_s, dat_s;
  logic [4:0] pins_s;
  logic sclk_q, ce_q;
  logic [5:0] bit_cnt;
  logic [7:0] addr_sr;
  logic [WORD_W-1:0] data_sr, ctrl, out_sr;
  logic rd_act;
  logic unlock_ff, lock_en;
  logic [2:0] pe_field;
  logic [15:0] ph_cnt, div_at;
  logic div_seen, pump_up;
  logic [7:0] sys_cnt;
  logic sys_clk;

  // all link and pin inputs pass two flip-flops
  plp_sync #(.W(8)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({bidir_pins_i, link.data_line, link.ce, link.sclk}),
    .q({pins_s, dat_s, ce_s, sclk_s})
  );

  // edges of the serial clock inside a frame
  wire sc_rise = ce_s && sclk_s && !sclk_q;
  wire sc_fall = ce_s && !sclk_s && sclk_q;
  wire ce_fall = !ce_s && ce_q;
  wire ctrl_load = ce_fall && addr_sr == ADDR_CTRL && bit_cnt == FRAME_BITS;
  wire unlock_rst = ctrl_load && data_sr[C_URST];
  wire rd_start = sc_fall && bit_cnt == TURN_BIT && addr_sr == ADDR_READ;

  // control fields
  wire [3:0] od_out_bits = ctrl[C_OD +: 4];
  wire [3:0] sel_bits = ctrl[C_SEL +: 4];
  wire [4:0] dir_bits = ctrl[C_DIR +: 5];
  wire [4:0] bidir_out_bits = ctrl[C_BOUT +: 5];
  wire sel_clk = ctrl[C_SEL_CLK];
  wire port_en = sel_bits == 4'h0;
  wire standby_now = &ref_select_bits;
  wire clk_half_sel = xtal_sel == XTAL_4M5;
  wire [7:0] sys_half = clk_half_sel ? SYSCLK_B_HALF : SYSCLK_A_HALF;
  wire ref_bad = !div_seen || div_at > UNLOCK_TOL_CYC;

  // readback word; sample bits of output pins carry the raw level
  wire [WORD_W-1:0] rb_word = {5'h00, pe_field, lock_en, unlock_ff, pins_s,
                               dir_bits, od_out_bits};

  // serial receive: bits counted on rising edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk_q <= 1'b0;
      ce_q <= 1'b0;
      bit_cnt <= 6'h00;
      addr_sr <= 8'h00;
      data_sr <= '0;
    end else begin
      sclk_q <= sclk_s;
      ce_q <= ce_s;
      if (!ce_s) begin
        bit_cnt <= 6'h00;
      end else if (sc_rise) begin
        if (bit_cnt != 6'h3f) begin
          bit_cnt <= bit_cnt + 6'h01;
        end
        if (bit_cnt < ADDR_BITS) begin
          addr_sr <= {dat_s, addr_sr[7:1]};
        end else if (bit_cnt > ADDR_BITS) begin
          data_sr <= {dat_s, data_sr[WORD_W-1:1]};
        end
      end
    end
  end

  // control word taken only when a whole frame ended cleanly
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= CTRL_RESET;
    end else if (ctrl_load) begin
      ctrl <= data_sr;
    end
  end

  // serial transmit: pins captured on the ninth falling edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_sr <= '0;
      rd_act <= 1'b0;
    end else if (!ce_s) begin
      rd_act <= 1'b0;
    end else if (rd_start) begin
      out_sr <= rb_word;
      rd_act <= 1'b1;
    end else if (sc_fall && rd_act) begin
      out_sr <= {1'b0, out_sr[WORD_W-1:1]};
    end
  end
  assign link.data_d_o = out_sr[0];
  assign link.data_d_oe = rd_act;

  // phase measurement once per reference cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ph_cnt <= 16'h0000;
      div_at <= 16'h0000;
      div_seen <= 1'b0;
      pe_field <= 3'h0;
      pump_up <= 1'b0;
    end else if (ref_pulse) begin
      ph_cnt <= 16'h0000;
      div_seen <= div_pulse;
      div_at <= 16'h0000;
      pe_field <= pe_quant(div_at);
      pump_up <= !div_pulse;
    end else begin
      if (ph_cnt != 16'hffff) begin
        ph_cnt <= ph_cnt + 16'h0001;
      end
      if (div_pulse && !div_seen) begin
        div_seen <= 1'b1;
        div_at <= ph_cnt;
        pump_up <= 1'b0;
      end
    end
  end

  // unlock and lock enable: a strobe in the reset cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unlock_ff <= 1'b0;
      lock_en <= 1'b0;
    end else begin
      if (ref_pulse && ref_bad) begin
        unlock_ff <= 1'b1;
      end else if (unlock_rst) begin
        unlock_ff <= 1'b0;
      end
      if (ref_pulse) begin
        lock_en <= 1'b1;
      end else if (unlock_rst) begin
        lock_en <= 1'b0;
      end
    end
  end

  // system clock divider, 50 percent duty
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_cnt <= 8'h00;
      sys_clk <= 1'b0;
    end else if (sys_cnt >= sys_half - 8'h01) begin
      sys_cnt <= 8'h00;
      sys_clk <= !sys_clk;
    end else begin
      sys_cnt <= sys_cnt + 8'h01;
    end
  end

  // pin drivers, all registered so pins never glitch on decode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      open_drain_pins_o <= 4'h0;
      open_drain_pins_oe <= 4'h0;
      bidir_pins_o <= 5'h00;
      bidir_pins_oe <= 5'h00;
      standby <= 1'b1;
      counter_sel <= 4'h0;
      test_mode <= 1'b0;
    end else begin
      open_drain_pins_oe <= od_out_bits;
      bidir_pins_o <= bidir_out_bits;
      bidir_pins_oe <= port_en ? dir_bits : 5'h00;
      if (sel_clk && !standby_now) begin
        bidir_pins_o[0] <= sys_clk;
        bidir_pins_oe[0] <= 1'b1;
      end
      standby <= standby_now;
      counter_sel <= {1'b0, sel_bits[2:0]}; // top bit unused, three input selects only
      test_mode <= ctrl[C_TEST];
    end
  end

  // both detector pins carry the same result, pin b floats while the float bit is set; float in standby
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_out_a_o <= 1'b0;
      phase_out_a_oe <= 1'b0;
      phase_out_b_o <= 1'b0;
      phase_out_b_oe <= 1'b0;
    end else begin
      phase_out_a_o <= 1'b1;
      phase_out_b_o <= 1'b1;
      phase_out_a_oe <= pump_up && !standby_now;
      phase_out_b_oe <= pump_up && !standby_now && !ctrl[C_FLOAT];
    end
  end
endmodule // plp_dev
`default_nettype wire

// >>> plp_pkg.sv
// constants and types shared by both ends of the port and lock-status link
`default_nettype none
package plp_pkg;
  // serial frame: 8 address bits, one turnaround bit, 24 data bits, lsb first
  localparam logic [7:0] ADDR_CTRL = 8'hd2;
  localparam logic [7:0] ADDR_READ = 8'hd3;
  localparam int WORD_W = 24;
  localparam logic [5:0] ADDR_BITS = 6'h08;
  localparam logic [5:0] TURN_BIT = 6'h09;
  localparam logic [5:0] FRAME_BITS = 6'h21;
  // control word fields
  localparam int C_OD = 0;
  localparam int C_SEL = 4;
  localparam int C_SEL_CLK = 7;
  localparam int C_DIR = 8;
  localparam int C_BOUT = 13;
  localparam int C_URST = 18;
  localparam int C_TEST = 19;
  localparam int C_FLOAT = 20;
  localparam logic [WORD_W-1:0] CTRL_RESET = 24'h000000;
  // readback word fields
  localparam int R_OD = 0;
  localparam int R_DIR = 4;
  localparam int R_PIN = 9;
  localparam int R_UNLOCK = 14;
  localparam int R_LOCKEN = 15;
  localparam int R_PE = 16;
  // crystal setting codes
  localparam logic [1:0] XTAL_4M5 = 2'h1;
  // timing
  localparam int CLK_NS = 4;
  localparam int ACLK_KHZ = 250000;
  localparam int SCLK_HALF_NS = 500;
  localparam logic [7:0] SCLK_HALF_CYC = 8'((SCLK_HALF_NS + CLK_NS - 1) / CLK_NS);
  localparam int SYSCLK_A_KHZ = 600;
  localparam int SYSCLK_B_KHZ = 750;
  localparam logic [7:0] SYSCLK_A_HALF = 8'(ACLK_KHZ / (2 * SYSCLK_A_KHZ));
  localparam logic [7:0] SYSCLK_B_HALF = 8'(ACLK_KHZ / (2 * SYSCLK_B_KHZ));
  localparam int PE_STEP_NS = 550;
  localparam logic [15:0] PE_STEP_CYC = 16'(PE_STEP_NS / CLK_NS);
  localparam int UNLOCK_TOL_NS = 7150;
  localparam logic [15:0] UNLOCK_TOL_CYC = 16'(UNLOCK_TOL_NS / CLK_NS);
  // host register map
  localparam logic [7:0] REG_WORD = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_READBACK = 8'h0c;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {HS_IDLE, HS_LEAD, HS_LOW, HS_HIGH, HS_TAIL} plp_host_st_t;
endpackage
`default_nettype wire

// >>> plp_link_if.sv
// three-wire serial link between host and port device
`timescale 1ns/100ps
`default_nettype none
interface plp_link_if;
  logic ce;
  logic sclk;
  logic data_h_o;
  logic data_h_oe;
  logic data_d_o;
  logic data_d_oe;
  logic data_line;
  // data wire with pull-up; host wins a collision
  assign data_line = data_h_oe ? data_h_o : (data_d_oe ? data_d_o : 1'b1);
  modport host (output ce, sclk, data_h_o, data_h_oe, input data_line);
  modport dev (input ce, sclk, data_line, output data_d_o, data_d_oe);
endinterface
`default_nettype wire

// >>> plp_sync.sv
// two flip-flop synchroniser for levels from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module plp_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  // first stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // plp_sync
`default_nettype wire

// >>> plp_host.sv
// host end: axi4-lite registers driving the three-wire serial link
`timescale 1ns/100ps
`default_nettype none
module plp_host
  import plp_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // serial link
  plp_link_if.host link
);
  import plp_pkg::*;

  plp_host_st_t st;
  logic [7:0] aw_a;
  logic [31:0] w_d;
  logic aw_got, w_got;
  logic [WORD_W-1:0] word, readback, rx;
  logic [32:0] sr;
  logic [7:0] tim;
  logic [5:0] bit_idx;
  logic busy, is_read, dat_s;

  plp_sync #(.W(1)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(link.data_line),
    .q(dat_s)
  );

  // register decode; commands are ignored while a frame runs
  wire do_wr = aw_got && w_got && !s_axi_bvalid;
  wire wr_word = do_wr && aw_a == REG_WORD;
  wire wr_cmd = do_wr && aw_a == REG_CMD && !busy;
  wire wr_ok = aw_a == REG_WORD || aw_a == REG_CMD;
  wire start_wr = wr_cmd && w_d[0];
  wire start_rd = wr_cmd && !w_d[0] && w_d[1];
  wire rd_hit = s_axi_araddr == REG_WORD || s_axi_araddr == REG_STATUS ||
                s_axi_araddr == REG_READBACK || s_axi_araddr == REG_CMD;
  wire [31:0] rd_mux = s_axi_araddr == REG_WORD ? {8'h00, word} :
                       s_axi_araddr == REG_STATUS ? {31'h00000000, busy} :
                       s_axi_araddr == REG_READBACK ? {8'h00, readback} : 32'h00000000;
  wire half_done = tim >= SCLK_HALF_CYC - 8'h01;

  // axi write channel; address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OK;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_a <= 8'h00;
      w_d <= 32'h00000000;
      word <= '0; // test bit stays zero after reset
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_a <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        w_d <= s_axi_wdata;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OK : RESP_SLVERR;
      end
      if (wr_word && s_axi_wstrb == 4'hf) begin
        word <= w_d[WORD_W-1:0];
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // axi read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? RESP_OK : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // serial frame engine, clock made by dividing aclk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= HS_IDLE;
      link.ce <= 1'b0;
      link.sclk <= 1'b0;
      link.data_h_o <= 1'b0;
      link.data_h_oe <= 1'b0;
      sr <= '0;
      rx <= '0;
      readback <= '0;
      tim <= 8'h00;
      bit_idx <= 6'h00;
      busy <= 1'b0;
      is_read <= 1'b0;
    end else begin
      tim <= half_done ? 8'h00 : tim + 8'h01;
      case (st)
        HS_IDLE: begin
          tim <= 8'h00;
          bit_idx <= 6'h00;
          if (start_wr || start_rd) begin
            sr <= start_wr ? {word, 1'b0, ADDR_CTRL} : {24'h000000, 1'b0, ADDR_READ};
            link.data_h_o <= start_wr ? ADDR_CTRL[0] : ADDR_READ[0];
            link.data_h_oe <= 1'b1;
            link.ce <= 1'b1;
            is_read <= start_rd;
            busy <= 1'b1;
            st <= HS_LEAD;
          end
        end
        HS_LEAD: begin
          if (half_done) begin
            st <= HS_LOW;
          end
        end
        HS_LOW: begin
          if (half_done) begin
            link.sclk <= 1'b1;
            st <= HS_HIGH;
          end
        end
        HS_HIGH: begin
          if (half_done) begin
            if (is_read && bit_idx >= TURN_BIT) begin
              rx <= {dat_s, rx[WORD_W-1:1]};
            end
            link.sclk <= 1'b0;
            sr <= {1'b0, sr[32:1]};
            link.data_h_o <= sr[1];
            if (is_read && bit_idx == ADDR_BITS) begin
              link.data_h_oe <= 1'b0;
            end
            bit_idx <= bit_idx + 6'h01;
            st <= (bit_idx == FRAME_BITS - 6'h01) ? HS_TAIL : HS_LOW;
          end
        end
        HS_TAIL: begin
          link.data_h_oe <= 1'b0;
          if (half_done) begin
            link.ce <= 1'b0;
            busy <= 1'b0;
            if (is_read) begin
              readback <= rx;
            end
            st <= HS_IDLE;
          end
        end
        default: begin
          st <= HS_IDLE;
        end
      endcase
    end
  end
endmodule // plp_host
`default_nettype wire

// >>> plp_link_asserts.sv
// protocol assertions on the serial link between host and device ends
`timescale 1ns/100ps
`default_nettype none
module plp_link_asserts
  import plp_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // link wires
  input wire logic ce,
  input wire logic sclk,
  input wire logic data_h_o,
  input wire logic data_h_oe,
  input wire logic data_d_o,
  input wire logic data_d_oe
);
  import plp_pkg::*;
  logic [7:0] hi_cnt;
  logic [7:0] lo_cnt;
  logic [5:0] rises;
  logic sclk_q;
  // run lengths of sclk and rises per frame; rises cleared between frames
  always_ff @(posedge aclk) begin
    hi_cnt <= sclk ? hi_cnt + 8'h01 : 8'h00;
    lo_cnt <= sclk ? 8'h00 : lo_cnt + 8'h01;
    sclk_q <= sclk;
    rises <= !ce ? 6'h00 : rises + 6'(sclk && !sclk_q);
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // eight quiet cycles: long enough for the synchronised ce fall to land
  sequence s_quiet;
    !ce [*8];
  endsequence
  a_reset_idle: assert property ($rose(aresetn) |-> !ce && !sclk && !data_h_oe && !data_d_oe)
    else $error("link not idle after reset");
  a_sclk_idle: assert property (!ce |-> !sclk)
    else $error("serial clock moves outside a frame");
  a_sclk_high: assert property ($fell(sclk) |-> hi_cnt == SCLK_HALF_CYC)
    else $error("serial clock high time wrong");
  a_frame_len: assert property ($fell(ce) |-> rises == FRAME_BITS)
    else $error("frame rise count wrong");
  a_dev_turn: assert property ($rose(data_d_oe) |-> ce && rises == 6'h09)
    else $error("device drives before ninth fall");
  a_dev_quiet: assert property (s_quiet |-> !data_d_oe)
    else $error("device drives outside a frame");
  a_dev_shift: assert property (data_d_oe && $past(data_d_oe) && $changed(data_d_o)
      |-> !sclk && lo_cnt < 8'h08)
    else $error("device data changes away from a falling edge");
  a_host_stable: assert property (sclk && data_h_oe && $past(data_h_oe) |-> $stable(data_h_o))
    else $error("host data changes while clock high");
endmodule // plp_link_asserts
`default_nettype wire

// >>> pll_port_lock_status_tb.sv
// testbench: axi4-lite host end driving the device end over the serial link
`timescale 1ns/100ps
`default_nettype none
module pll_port_lock_status_tb;
  import plp_pkg::*;
  localparam logic [4:0] DIR = 5'h16;
  localparam logic [4:0] BOUT = 5'h13;
  localparam logic [23:0] W1 = 24'h00000a | (24'(DIR) << C_DIR) | (24'(BOUT) << C_BOUT);
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, d;
  logic [3:0] ref_select_bits = 4'h3;
  logic [1:0] xtal_sel = 2'h1;
  logic ref_pulse = 1'b0, div_pulse = 1'b0;
  logic standby, test_mode, phase_out_a_o, phase_out_a_oe, phase_out_b_o, phase_out_b_oe;
  logic [3:0] counter_sel, open_drain_pins_o, open_drain_pins_oe;
  logic [4:0] bidir_pins_i, bidir_pins_o, bidir_pins_oe;
  logic [4:0] ext_pins = 5'h0d;
  int errors = 0, n_checks = 0, n;
  always #2 aclk = ~aclk;
  // pin level: own drive where enabled, else the outside world
  assign bidir_pins_i = (bidir_pins_oe & bidir_pins_o) | (~bidir_pins_oe & ext_pins);
  plp_link_if i_plp_link_if ();
  plp_host i_plp_host (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .link(i_plp_link_if.host));
  plp_dev i_plp_dev (.aclk, .aresetn, .link(i_plp_link_if.dev), .ref_select_bits, .xtal_sel,
    .ref_pulse, .div_pulse, .standby, .counter_sel, .test_mode, .open_drain_pins_o,
    .open_drain_pins_oe, .bidir_pins_i, .bidir_pins_o, .bidir_pins_oe, .phase_out_a_o,
    .phase_out_a_oe, .phase_out_b_o, .phase_out_b_oe);
  plp_link_asserts i_plp_link_asserts (.aclk, .aresetn, .ce(i_plp_link_if.ce),
    .sclk(i_plp_link_if.sclk), .data_h_o(i_plp_link_if.data_h_o),
    .data_h_oe(i_plp_link_if.data_h_oe), .data_d_o(i_plp_link_if.data_d_o),
    .data_d_oe(i_plp_link_if.data_d_oe));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task results;
    if (errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // one write; valids drop when taken, bready held until the answer
  task wr(input logic [7:0] a, input logic [31:0] wd, input logic [1:0] er);
    bit done;
    done = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= wd;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // no cycle count assumed: only the watchdog ends a hung wait
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        check(32'(s_axi_bresp), 32'(er));
        done = 1;
      end
    end
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] rdat, output logic [1:0] r);
    bit done;
    done = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        rdat = s_axi_rdata;
        r = s_axi_rresp;
        done = 1;
      end
    end
    s_axi_rready <= 1'b0;
  endtask
  // poll busy; a frame lasts about 8500 cycles
  task wait_idle;
    logic [31:0] st;
    logic [1:0] r;
    st = 32'h1;
    repeat (4) @(posedge aclk);
    while (st[0] !== 1'b0) rd(REG_STATUS, st, r);
    repeat (12) @(posedge aclk);
  endtask
  task send(input logic [23:0] w);
    wr(REG_WORD, {8'h00, w}, RESP_OK);
    wr(REG_CMD, 32'h1, RESP_OK);
    wait_idle;
  endtask
  task rd_frame(output logic [31:0] rb);
    logic [1:0] r;
    wr(REG_CMD, 32'h2, RESP_OK);
    wait_idle;
    rd(REG_READBACK, rb, r);
  endtask
  // reference pulse, then divider pulse after gap cycles (none for gap 0)
  task pulses(input int gap, input logic b_on);
    @(posedge aclk);
    ref_pulse <= 1'b1;
    @(posedge aclk);
    ref_pulse <= 1'b0;
    if (gap > 0) begin
      repeat (10) @(posedge aclk);
      check(32'({phase_out_a_oe, phase_out_a_o}), 32'h3);
      check(32'({phase_out_b_oe, phase_out_b_o}), 32'({b_on, 1'b1}));
      repeat (gap - 11) @(posedge aclk);
      div_pulse <= 1'b1;
      @(posedge aclk);
      div_pulse <= 1'b0;
    end
  endtask
  // length of one high phase of the shared pin, in cycles
  task hi_run(output int len);
    len = 0;
    for (int i = 0; i < 1000 && bidir_pins_o[0] !== 1'b0; i++) @(posedge aclk);
    for (int i = 0; i < 1000 && bidir_pins_o[0] !== 1'b1; i++) @(posedge aclk);
    while (bidir_pins_o[0] === 1'b1 && len < 1000) begin
      @(posedge aclk);
      len++;
    end
  endtask
  // watchdog: eight frames need about 68000 cycles
  initial begin
    repeat (95000) @(posedge aclk);
    errors++;
    results;
  end
  initial begin
    logic [1:0] r;
    repeat (5) @(posedge aclk);
    check(32'(open_drain_pins_oe), 32'h0);
    check(32'(bidir_pins_oe), 32'h0);
    aresetn <= 1'b1;
    rd(REG_WORD, d, r);
    check(d, 32'(CTRL_RESET));
    rd(8'h40, d, r);
    check({d[29:0], r}, 32'(RESP_SLVERR));
    wr(8'h40, 32'h1, RESP_SLVERR);
    wr(REG_WORD, {8'h00, W1}, RESP_OK);
    rd(REG_WORD, d, r);
    check(d, {8'h00, W1});
    wr(REG_CMD, 32'h1, RESP_OK);
    repeat (4000) @(posedge aclk);
    check(32'(open_drain_pins_oe), 32'h0);
    wait_idle;
    check(32'({open_drain_pins_oe, open_drain_pins_o}), 32'ha0);
    check(32'(bidir_pins_oe), 32'(DIR));
    check(32'(bidir_pins_o & DIR), 32'(BOUT & DIR));
    rd_frame(d);
    check(32'(d[8:0]), 32'({DIR, 4'ha}));
    check(32'(d[13:9] & ~DIR), 32'(ext_pins & ~DIR));
    send(W1 | 24'(1 << (C_SEL + 1)));
    check(32'(bidir_pins_oe), 32'h0);
    check(32'({counter_sel, test_mode}), 32'({4'h2, 1'b0}));
    send(W1 | 24'(1 << C_SEL_CLK));
    for (int k = 0; k < 2; k++) begin
      xtal_sel <= k ? XTAL_4M5 : 2'h0;
      repeat (500) @(posedge aclk);
      hi_run(n);
      check(32'(n), k ? 32'(SYSCLK_B_HALF) : 32'(SYSCLK_A_HALF));
    end
    check(32'(bidir_pins_oe), 32'h1);
    ref_select_bits <= 4'hf;
    repeat (8) @(posedge aclk);
    check(32'({standby, bidir_pins_oe, open_drain_pins_oe}), 32'({1'b1, 5'h00, 4'ha}));
    ref_select_bits <= 4'h3;
    pulses(480, 1'b1);
    send(24'(1 << C_URST) | 24'(1 << C_FLOAT));
    rd_frame(d);
    check(32'(d[15:14]), 32'h0);
    pulses(480, 1'b0);
    pulses(0, 1'b0);
    rd_frame(d);
    check(32'(d[18:14]), 32'h0e);
    pulses(0, 1'b0);
    rd_frame(d);
    check(32'(d[14]), 32'h1);
    results;
  end
endmodule // pll_port_lock_status_tb
`default_nettype wire
